// >>> inc/prsd_map.vh
// constants for the clock configuration strap decoder
`ifndef PRSD_MAP_VH
`define PRSD_MAP_VH
// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define PRSD_ADDR_STATUS  4'h0
`define PRSD_ADDR_CTRL    4'h4
// status fields: [2:0] mem ratio x2, [6:3] cpu ratio x2, [11:7] readback,
// [12] bypass, [13] clock off, [14] reserved strap, [19:15] strap
`define PRSD_CTRL_RESET   1'h0
// ---------------------------------------------------------------
// ratio codes, multiplier times two
// ---------------------------------------------------------------
`define PRSD_X2_1    3'h2
`define PRSD_X2_1P5  3'h3
`define PRSD_X2_2    3'h4
`define PRSD_X2_2P5  3'h5
`define PRSD_X2_3    3'h6
`define PRSD_C2_2    4'h4
`define PRSD_C2_2P5  4'h5
`define PRSD_C2_3    4'h6
`define PRSD_C2_3P5  4'h7
`define PRSD_C2_4    4'h8
`define PRSD_C2_4P5  4'h9
// ---------------------------------------------------------------
// readback codes per processor multiplier
// ---------------------------------------------------------------
`define PRSD_RB_2    5'h04
`define PRSD_RB_2B   5'h05
`define PRSD_RB_2P5  5'h06
`define PRSD_RB_3    5'h18
`define PRSD_RB_3P5  5'h1e
`define PRSD_RB_4    5'h1a
`define PRSD_RB_4P5  5'h07
`define PRSD_RB_OFF0 5'h0f
`define PRSD_RB_OFF1 5'h1f
`endif

// >>> core/prsd_strap_decoder.v
// clock configuration strap decoder with axi4-lite status port
`include "prsd_map.vh"
module prsd_strap_decoder (
  input  wire        clk,
  input  wire        rst,
  input  wire        hard_reset_line_n,
  input  wire [4:0]  pll_strap,
  output reg  [2:0]  mem_ratio_x2_q,
  output reg  [3:0]  cpu_ratio_x2_q,
  output reg  [4:0]  cpu_multiplier_readback_q,
  output reg         bypass_q,
  output reg         clock_off_q,
  output reg         periph_pll_en_q,
  output reg         cpu_clk_en_q,
  output reg         reserved_strap_q,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  // ---------------------------------------------------------------
  // pin synchronisers, one pair of flops per strap bit
  // ---------------------------------------------------------------
  reg [4:0] strap_m_q;
  reg [4:0] strap_s_q;
  reg       hrst_m_q;
  reg       hrst_s_q;
  reg       cpu_gate_q;
  genvar    gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_strap_sync
      always @(posedge clk) begin
        strap_m_q[gi] <= pll_strap[gi];
        strap_s_q[gi] <= strap_m_q[gi];
      end
    end
  endgenerate

  // hard reset pin goes through the same two-flop chain
  always @(posedge clk) begin
    hrst_m_q <= hard_reset_line_n;
    hrst_s_q <= hrst_m_q;
  end

  // ---------------------------------------------------------------
  // strap decode
  // ---------------------------------------------------------------
  reg [2:0] mem_d;
  reg [3:0] cpu_d;
  reg [4:0] rb_d;
  reg       byp_d;
  reg       off_d;
  reg       rsv_d;
  always @* begin
    mem_d = `PRSD_X2_1;
    cpu_d = `PRSD_C2_2;
    rb_d  = `PRSD_RB_2;
    byp_d = 1'b0;
    off_d = 1'b0;
    rsv_d = 1'b0;
    case (strap_s_q)
      5'h00: begin mem_d = `PRSD_X2_3;   cpu_d = `PRSD_C2_2P5; rb_d = `PRSD_RB_2P5; end
      5'h01: begin mem_d = `PRSD_X2_3;   cpu_d = `PRSD_C2_3;   rb_d = `PRSD_RB_3;   end
      5'h02: begin mem_d = `PRSD_X2_1;   cpu_d = `PRSD_C2_2;   rb_d = `PRSD_RB_2B;  end
      5'h03: begin byp_d = 1'b1;         cpu_d = `PRSD_C2_2;   rb_d = `PRSD_RB_2B;  end
      5'h04: begin mem_d = `PRSD_X2_2;   cpu_d = `PRSD_C2_2;   rb_d = `PRSD_RB_2B;  end
      5'h05: begin byp_d = 1'b1;         cpu_d = `PRSD_C2_2P5; rb_d = `PRSD_RB_2P5; end
      5'h07: begin byp_d = 1'b1;         cpu_d = `PRSD_C2_3;   rb_d = `PRSD_RB_3;   end
      5'h08: begin mem_d = `PRSD_X2_1;   cpu_d = `PRSD_C2_3;   rb_d = `PRSD_RB_3;   end
      5'h0a: begin mem_d = `PRSD_X2_2;   cpu_d = `PRSD_C2_4P5; rb_d = `PRSD_RB_4P5; end
      5'h0c: begin mem_d = `PRSD_X2_2;   cpu_d = `PRSD_C2_2P5; rb_d = `PRSD_RB_2P5; end
      5'h0e: begin mem_d = `PRSD_X2_2;   cpu_d = `PRSD_C2_3;   rb_d = `PRSD_RB_3;   end
      5'h10: begin mem_d = `PRSD_X2_3;   cpu_d = `PRSD_C2_2;   rb_d = `PRSD_RB_2;   end
      5'h12: begin mem_d = `PRSD_X2_1P5; cpu_d = `PRSD_C2_2;   rb_d = `PRSD_RB_2;   end
      5'h14: begin mem_d = `PRSD_X2_2;   cpu_d = `PRSD_C2_3P5; rb_d = `PRSD_RB_3P5; end
      5'h16: begin mem_d = `PRSD_X2_2;   cpu_d = `PRSD_C2_4;   rb_d = `PRSD_RB_4;   end
      5'h18: begin mem_d = `PRSD_X2_2P5; cpu_d = `PRSD_C2_3;   rb_d = `PRSD_RB_3;   end
      5'h1a: begin mem_d = `PRSD_X2_1;   cpu_d = `PRSD_C2_4;   rb_d = `PRSD_RB_4;   end
      5'h1c: begin mem_d = `PRSD_X2_1P5; cpu_d = `PRSD_C2_3;   rb_d = `PRSD_RB_3;   end
      5'h1d: begin mem_d = `PRSD_X2_1P5; cpu_d = `PRSD_C2_2P5; rb_d = `PRSD_RB_2P5; end
      5'h1e: begin off_d = 1'b1;         rb_d = `PRSD_RB_OFF0; end
      5'h1f: begin off_d = 1'b1;         rb_d = `PRSD_RB_OFF1; end
      default: begin rsv_d = 1'b1; end
    endcase
  end

  // ---------------------------------------------------------------
  // capture while hard reset is low, hold afterwards
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      mem_ratio_x2_q            <= `PRSD_X2_1;
      cpu_ratio_x2_q            <= `PRSD_C2_2;
      cpu_multiplier_readback_q <= `PRSD_RB_2;
      bypass_q                  <= 1'b0;
      clock_off_q               <= 1'b1;
      reserved_strap_q          <= 1'b0;
      periph_pll_en_q           <= 1'b0;
    end else begin
      if (!hrst_s_q) begin
        mem_ratio_x2_q            <= byp_d ? `PRSD_X2_1 : mem_d;
        cpu_ratio_x2_q            <= cpu_d;
        cpu_multiplier_readback_q <= rb_d;
        bypass_q                  <= byp_d;
        clock_off_q               <= off_d;
        reserved_strap_q          <= rsv_d;
        periph_pll_en_q           <= ~byp_d & ~off_d & ~rsv_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // processor clock enable
  // ---------------------------------------------------------------
  // runs only out of hard reset, never in clock-off or on a reserved strap;
  // the ctrl bit lets software stop it
  always @(posedge clk) begin
    if (rst) begin
      cpu_clk_en_q <= 1'b0;
    end else begin
      cpu_clk_en_q <= hrst_s_q & ~clock_off_q & ~reserved_strap_q & ~cpu_gate_q;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  reg        aw_got_q;
  reg        w_got_q;
  reg [3:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg        wstrb0_q;
  wire       aw_ok = aw_got_q | s_axi_awvalid;
  wire       w_ok  = w_got_q | s_axi_wvalid;
  wire [3:0] wa    = aw_got_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd   = w_got_q ? wdata_q : s_axi_wdata;
  wire       ws0   = w_got_q ? wstrb0_q : s_axi_wstrb[0];
  wire       wr_go = aw_ok & w_ok & ~s_axi_bvalid;
  assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      aw_got_q     <= 1'b0;
      w_got_q      <= 1'b0;
      awaddr_q     <= 4'h0;
      wdata_q      <= 32'h0;
      wstrb0_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      cpu_gate_q   <= `PRSD_CTRL_RESET;
    end else begin
      if (s_axi_awvalid & s_axi_awready & ~wr_go) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready & ~wr_go) begin
        w_got_q  <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wa == `PRSD_ADDR_CTRL) begin
          s_axi_bresp <= 2'h0;
          if (ws0)
            cpu_gate_q <= wd[0];
        end else if (wa == `PRSD_ADDR_STATUS) begin
          s_axi_bresp <= 2'h0;
        end else begin
          s_axi_bresp <= 2'h2;
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  // status fields packed once so the read mux stays a plain select
  wire [31:0] status_word = {12'h0, strap_s_q, reserved_strap_q, clock_off_q,
                             bypass_q, cpu_multiplier_readback_q,
                             cpu_ratio_x2_q, mem_ratio_x2_q};
  wire [31:0] ctrl_word   = {31'h0, cpu_gate_q};

  always @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        `PRSD_ADDR_STATUS: s_axi_rdata <= status_word;
        `PRSD_ADDR_CTRL: s_axi_rdata <= ctrl_word;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// >>> sim/prsd_sva.sv
// concurrent checks on the strap decoder ports
`include "prsd_map.vh"
module prsd_sva (
  input wire        clk, rst, hard_reset_line_n, bypass_q, clock_off_q,
  input wire        periph_pll_en_q, cpu_clk_en_q, reserved_strap_q,
  input wire [2:0]  mem_ratio_x2_q,
  input wire [3:0]  cpu_ratio_x2_q,
  input wire [4:0]  cpu_multiplier_readback_q,
  input wire        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire [1:0]  s_axi_rresp,
  input wire [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // pin held low / high long enough to settle
  // ----------------------------------------
  sequence s_pin_low; !hard_reset_line_n [*4]; endsequence
  sequence s_pin_high; hard_reset_line_n [*5]; endsequence
  a_bypass_one_to_one: assert property (bypass_q |-> mem_ratio_x2_q == `PRSD_X2_1 && !periph_pll_en_q)
    else $error("bypass ratio or pll wrong");
  a_off_no_clocks: assert property (clock_off_q |-> !cpu_clk_en_q && !periph_pll_en_q)
    else $error("clocks run in off mode");
  a_rsv_no_clocks: assert property (reserved_strap_q |-> !cpu_clk_en_q && !periph_pll_en_q)
    else $error("clocks run on reserved strap");
  a_decode_held: assert property (s_pin_high |-> $stable({mem_ratio_x2_q, cpu_ratio_x2_q,
    cpu_multiplier_readback_q, bypass_q, clock_off_q, reserved_strap_q})) else $error("decode moved");
  a_cpu_in_reset: assert property (s_pin_low |-> !cpu_clk_en_q)
    else $error("cpu clock during hard reset");
  a_rb_top_ratio: assert property (cpu_ratio_x2_q == `PRSD_C2_4P5 |-> cpu_multiplier_readback_q == `PRSD_RB_4P5)
    else $error("readback wrong");
  a_mem_legal: assert property (!clock_off_q |-> mem_ratio_x2_q inside {[2:6]})
    else $error("mem ratio out of set");
  a_cpu_legal: assert property (cpu_ratio_x2_q inside {[4:9]})
    else $error("cpu ratio out of set");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rd_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule
bind prsd_strap_decoder prsd_sva u_sva (.*);

// >>> sim/prsd_board.sv
// board side: merged hard reset line and configuration straps
module prsd_board (
  input  wire       clk,
  output wire       hard_reset_line_n,
  output reg  [4:0] pll_strap
);
  timeunit 1ns;
  timeprecision 1ps;
  reg  board_rst_n = 1'b1;
  reg  probe_hrst_n = 1'b1;
  reg  probe_trst_n = 1'b1;
  wire trst_n = probe_trst_n & hard_reset_line_n;
  assign hard_reset_line_n = board_rst_n & probe_hrst_n;
  initial pll_strap = 5'h00;
  // hold the line low with a code, release, then scramble the strap
  task apply(input [4:0] code, input probe, input [4:0] junk);
    @(posedge clk);
    pll_strap <= code;
    if (probe) probe_hrst_n <= 1'b0;
    else board_rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    {board_rst_n, probe_hrst_n} <= 2'b11;
    repeat (3) @(posedge clk);
    pll_strap <= junk;
    repeat (3) @(posedge clk);
  endtask
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the strap decoder
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  reg clk = 1'b0, rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  reg [31:0] s_axi_wdata = 32'h0, r;
  wire hard_reset_line_n, bypass_q, clock_off_q, periph_pll_en_q, cpu_clk_en_q, reserved_strap_q;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [4:0] pll_strap, cpu_multiplier_readback_q;
  wire [2:0] mem_ratio_x2_q;
  wire [3:0] cpu_ratio_x2_q;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [31:0] port_word = {17'h0, reserved_strap_q, clock_off_q, bypass_q,
                           cpu_multiplier_readback_q, cpu_ratio_x2_q, mem_ratio_x2_q};
  integer n_errors = 0, checks = 0, seed = 32'h6f58c6ff, i;
  reg [67:0] rq[$];
  reg [67:0] e;
  reg [1:0] bq[$];
  // per code: kind (0 run 1 bypass 2 off 3 reserved), mem x2, cpu x2, readback
  localparam logic [15:0] dec_tab [32] = '{16'h0ca6, 16'h0cd8, 16'h0485, 16'h1485,
    16'h0885, 16'h14a6, 16'h3484, 16'h14d8, 16'h04d8, 16'h3484, 16'h0927, 16'h3484,
    16'h08a6, 16'h3484, 16'h08d8, 16'h3484, 16'h0c84, 16'h3484, 16'h0684, 16'h3484,
    16'h08fe, 16'h3484, 16'h091a, 16'h3484, 16'h0ad8, 16'h3484, 16'h051a, 16'h3484,
    16'h06d8, 16'h06a6, 16'h208f, 16'h209f};
  prsd_strap_decoder u_dut (.*);
  prsd_board u_board (.*);
  always #2.5 clk = ~clk;
  task check(input [31:0] seen, input [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task wr(input [3:0] a, input [31:0] d, input [1:0] resp);
    bq.push_back(resp);
    @(posedge clk) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    @(negedge clk) while (!(s_axi_awready && s_axi_wready)) @(negedge clk);
    @(posedge clk) {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
    @(negedge clk) while (!s_axi_bvalid) @(negedge clk);
    @(posedge clk) s_axi_bready <= 1'b0;
  endtask
  // pr holds the expected {pll enable, cpu clock enable, response}
  task rd(input [3:0] a, input [31:0] x, input [31:0] m, input [3:0] pr);
    rq.push_back({pr, m, x & m});
    @(posedge clk) {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    @(negedge clk) while (!s_axi_arready) @(negedge clk);
    @(posedge clk) s_axi_arvalid <= 1'b0;
    @(negedge clk) while (!s_axi_rvalid) @(negedge clk);
    @(posedge clk) s_axi_rready <= 1'b0;
  endtask
  task rd_code(input [4:0] c);
    logic [15:0] t;
    logic [31:0] x;
    logic [31:0] m;
    t = dec_tab[c];
    x = {17'h0, t[13:12] == 2'd3, t[13:12] == 2'd2, t[13:12] == 2'd1, t[4:0], t[8:5], t[11:9]};
    m = (t[13:12] == 2'd2) ? 32'h7ff8 : 32'h7fff;
    rd(4'h0, x, m, {t[13:12] == 2'd0, t[13:12] < 2'd2, 2'h0});
    check(port_word & m, x & m);
  endtask
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) check({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      check(s_axi_rdata & e[63:32], e[31:0]);
      check({28'h0, periph_pll_en_q, cpu_clk_en_q, s_axi_rresp}, {28'h0, e[67:64]});
    end
  end
  initial begin
    #50us;
    n_errors = n_errors + 1;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 32'h2222, 32'h7fff, 4'h0);
    for (i = 0; i < 32; i = i + 1) begin
      r = $random(seed);
      u_board.apply(i[4:0], i[0], r[4:0]);
      rd_code(i[4:0]);
    end
    u_board.apply(5'h10, 1'b0, 5'h1f);
    wr(4'h4, 32'h1, 2'h0);
    rd(4'h0, 32'h0, 32'h0, 4'b1000);
    wr(4'h4, 32'h0, 2'h0);
    r = $random(seed);
    wr(4'h0, r, 2'h0);
    wr(4'hc, r, 2'h2);
    rd(4'h8, 32'h0, 32'hffffffff, 4'b1110);
    rd_code(5'h10);
    repeat (2) @(posedge clk);
    end_sim;
  end
endmodule
